// ==== smad_defs.svh ====
/*
 * constants for the system memory address decoder: register offsets, field positions,
 * reset values, window masks and region sizes in megabytes.
 * assumes inclusion by bare name from each design file that needs it.
 */
`ifndef SMAD_DEFS_SVH
`define SMAD_DEFS_SVH

// -----------------------------------------------------------------
// register byte offsets on the apb port
// -----------------------------------------------------------------
`define SMAD_REG_CTRL      8'h00
`define SMAD_REG_SEGATTR   8'h04
`define SMAD_REG_LOWTOP    8'h08
`define SMAD_REG_PORTMEM   8'h0C
`define SMAD_REG_PORTPF    8'h10
`define SMAD_REG_WIN0      8'h14
`define SMAD_REG_WINLAST   8'h30
`define SMAD_REG_STATUS    8'h34
`define SMAD_REG_SMMBASE   8'h38
`define SMAD_WIN_SHIFT     2

// -----------------------------------------------------------------
// control register fields
// -----------------------------------------------------------------
`define SMAD_CTRL_HOLE     0
`define SMAD_CTRL_SMM      1
`define SMAD_CTRL_ESMRAM   2
`define SMAD_CTRL_IGD      3
`define SMAD_CTRL_SMM_TOP_SEGMENT_LO  4
`define SMAD_CTRL_SMM_TOP_SEGMENT_HI  5
`define SMAD_CTRL_GMS_LO   8
`define SMAD_CTRL_GMS_HI   10
`define SMAD_CTRL_GTT      12
`define SMAD_CTRL_FLAT_LO  16
`define SMAD_CTRL_FLAT_HI  17
`define SMAD_CTRL_APER_LO  18
`define SMAD_CTRL_APER_HI  19
`define SMAD_CTRL_RESET    32'h0000_0000
`define SMAD_CTRL_MASK     32'h000F_173F

// -----------------------------------------------------------------
// segment attributes, windows, status
// -----------------------------------------------------------------
`define SMAD_SEG_COUNT     13
`define SMAD_SEG_BITS      26
`define SMAD_SEG_RESET     26'h000_0000
`define SMAD_SEG_TOP_IDX   4'hC
`define SMAD_WIN_COUNT     8
`define SMAD_WIN_EN        0
`define SMAD_MB_LO         20
`define SMAD_LIMIT_LO      16
`define SMAD_BASE_LO       4
`define SMAD_STAT_IWB      4
`define SMAD_STAT_CNT_LO   16

// -----------------------------------------------------------------
// address regions, in units of 1 MB unless noted
// -----------------------------------------------------------------
`define SMAD_LEGACY_MB     12'h000
`define SMAD_LEGACY_HI2    2'b11
`define SMAD_BIOS_NIBBLE   4'hF
`define SMAD_HOLE_MB       12'h00F
`define SMAD_MB_1          12'h001
`define SMAD_MB_2          12'h002
`define SMAD_MB_8          12'h008
`define SMAD_MB_ZERO       12'h000
`define SMAD_GMS_STEP      12'h002

// -----------------------------------------------------------------
// window masks
// -----------------------------------------------------------------
`define SMAD_MASK_4K       32'hFFFF_F000
`define SMAD_MASK_16K      32'hFFFF_C000
`define SMAD_MASK_512K     32'hFFF8_0000
`define SMAD_MASK_1M       32'hFFF0_0000
`define SMAD_MASK_64M      32'hFC00_0000
`define SMAD_MASK_128M     32'hF800_0000
`define SMAD_MASK_256M     32'hF000_0000
`define SMAD_MASK_512M     32'hE000_0000
`define SMAD_ADDR_ZERO     32'h0000_0000
`define SMAD_BE_NONE       8'h00

`endif

// ==== smad_pkg.sv ====
/*
 * types shared by the decoder files: request sources and routing targets.
 * assumes nothing beyond a systemverilog compiler.
 */
package smad_pkg;

	// who issued the memory access
	typedef enum logic [1:0]
	{
		SMAD_SRC_CPU,
		SMAD_SRC_DOWNLINK,
		SMAD_SRC_PORT,
		SMAD_SRC_IGFX
	} smad_src_t;

	// where the access is steered
	typedef enum logic [2:0]
	{
		SMAD_TGT_DRAM,
		SMAD_TGT_DOWNLINK,
		SMAD_TGT_PORT,
		SMAD_TGT_INTERNAL,
		SMAD_TGT_IGFX
	} smad_tgt_t;

endpackage

// ==== smad_seg_if.sv ====
/*
 * carrier between the top decoder and the legacy segment lookup.
 * assumes both ends sit on the same clock; the lookup is combinational.
 */
`timescale 1ns/1ps
interface smad_seg_if;
	logic [31:0] addr;      // access address
	logic        write;     // access direction
	logic [25:0] attr;      // read/write allow pairs, one pair per segment
	logic        hit;       // address lies in 768 kb .. 1 mb
	logic        allow;     // attribute for this direction is set

	modport lookup
	(
		input  addr,
		input  write,
		input  attr,
		output hit,
		output allow
	);

	modport user
	(
		output addr,
		output write,
		output attr,
		input  hit,
		input  allow
	);
endinterface

// ==== smad_legacy_seg.sv ====
/*
 * legacy attribute segment lookup: maps an address between 768 kb and 1 mb onto one of
 * thirteen segments and returns the attribute for the access direction.
 * assumes the segment attribute register is held by the instantiating module.
 */
`timescale 1ns/1ps
`include "smad_defs.svh"

module smad_legacy_seg
	import smad_pkg::*;
(
	// segment lookup carrier
	smad_seg_if.lookup seg
);

	logic [3:0] segIdx;     // 0..7 expansion, 8..11 extended bios, 12 system bios

	// ---------------------------------------------------------
	// segment index and direction attribute
	// ---------------------------------------------------------
	// 16 kb slices below the top 64 kb, one slice for the whole top 64 kb
	always_comb
	begin
		seg.hit = (seg.addr[31:`SMAD_MB_LO] == `SMAD_LEGACY_MB)
			&& (seg.addr[19:18] == `SMAD_LEGACY_HI2);                      // [RQ7]
		if (seg.addr[19:16] == `SMAD_BIOS_NIBBLE)
			segIdx = `SMAD_SEG_TOP_IDX;                                    // [RQ5]
		else
			segIdx = seg.addr[17:14];                                      // [RQ1] [RQ4]
		// even bit allows reads, odd bit allows writes
		seg.allow = seg.write ? seg.attr[{segIdx, 1'b1}] : seg.attr[{segIdx, 1'b0}]; // [RQ24]
	end

endmodule

// ==== smad_top.sv ====
/*
 * system memory address decoder: classifies each memory access and steers it to dram,
 * the chipset downlink, the graphics port, internal register windows or internal graphics.
 * configuration is held in registers reached over apb.
 * assumes requests come from logic on ref_clk; one decode result per request taken while clkEn is high, one cycle later.
 */
//
// Summary of operation
// RQ1 - expansion area: eight 16 kb segments, four states
// RQ2 - disabled segment dram is never relocated
// RQ3 - non-snooped port/downlink legacy accesses go dram
// RQ4 - extended bios: four segments, per-direction attributes
// RQ5 - top bios 64 kb segment, disabled after reset
// RQ6 - attributes let firmware shadow into dram
// RQ7 - thirteen attribute sections from 768k to 1m
// RQ8 - disabled segments default to the downlink
// RQ9 - writebacks to downlink unsupported, only flagged
// RQ10 - 1 mb to low top goes dram
// RQ11 - fixed hole 15-16 mb goes downlink
// RQ12 - smm segment 1/2/8 mb below stolen graphics
// RQ13 - smm processor access hits same dram address
// RQ14 - other sources into smm become invalid
// RQ15 - extended smram: non-smm or non-wb invalid
// RQ16 - smm-segment writebacks still complete to dram
// RQ17 - stolen vga memory 1 to 256 mb
// RQ18 - translation table 1 or 2 mb at top
// RQ19 - low top to 4 gb defaults downlink
// RQ20 - four host-bridge windows claimed internally
// RQ21 - port base/limit windows go to port
// RQ22 - graphics windows claimed when graphics enabled
// RQ23 - software keeps windows clear of fixed ranges
// RQ24 - segment direction attribute picks dram or downlink
//
`timescale 1ns/1ps
`include "smad_defs.svh"

module smad_top
	import smad_pkg::*;
(
	// clock, reset, enable
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	input  wire logic        clkEn,
	// apb register port
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	// access request
	input  wire logic        reqValid,
	input  wire logic [31:0] reqAddr,
	input  smad_src_t        reqSrc,
	input  wire logic        reqWrite,
	input  wire logic        reqSnoop,
	input  wire logic        reqSmm,
	input  wire logic        reqWb,
	input  wire logic        reqIwb,
	input  wire logic [7:0]  reqBe,
	// routing result
	output logic             rspValid,
	output smad_tgt_t        rspTarget,
	output logic [31:0]      rspAddr,
	output logic [7:0]       rspBe,
	output logic             rspInvalid
);

	// ---------------------------------------------------------
	// declarations
	// ---------------------------------------------------------
	logic        rstMeta;                       // reset release, first stage
	logic        rstN;                          // synchronised reset used everywhere
	logic [31:0] ctrl;                          // modes, enables and size selects
	logic [25:0] segAttr;                       // legacy segment attribute pairs
	logic [11:0] lowTop;                        // low_dram_top_boundary in mb
	logic [11:0] memBase, memLimit;             // port_mem_window base/limit
	logic [11:0] pfBase, pfLimit;               // port_prefetch_window base/limit
	logic [31:0] winReg [`SMAD_WIN_COUNT];      // window bases with enable in bit 0
	logic [31:0] winMask [`SMAD_WIN_COUNT];     // active compare mask per window
	logic [`SMAD_WIN_COUNT-1:0] winHit;         // address falls in an enabled window
	logic        iwbSticky;                     // writeback seen towards downlink
	logic [15:0] decodeCnt;                     // decoded requests, wraps
	logic [11:0] tsegMb, gmsMb, gttMb;          // region sizes in mb
	logic [11:0] stolenBase, smmBase;           // region bases in mb
	logic [11:0] addrMb;                        // request address in mb
	logic        inLegacy, inHole, inSmm, inStolen, inLow;
	logic        nsLegacy;                      // non-snooped port/downlink legacy access
	logic        apbAccess, apbDone, apbHit;    // apb phase decode
	logic [31:0] next_rdata;                    // read mux
	smad_tgt_t   next_tgt;
	logic [31:0] next_addr;
	logic [7:0]  next_be;
	logic        next_inv;
	logic        next_iwb;

	// ---------------------------------------------------------
	// reset release
	// ---------------------------------------------------------
	// asynchronous assert, two-stage release so all state leaves reset on one edge
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rstMeta <= 1'b0;
			rstN    <= 1'b0;
		end
		else
		begin
			rstMeta <= 1'b1;
			rstN    <= rstMeta;
		end
	end

	// ---------------------------------------------------------
	// apb slave
	// ---------------------------------------------------------
	// one wait state: pready rises in the second access cycle, so read data
	// and the error flag both come from flops
	assign apbAccess = psel && penable && !pready;
	assign apbDone   = psel && penable && pready;
	assign apbHit    = (paddr[1:0] == 2'b00) && (paddr <= `SMAD_REG_SMMBASE);

	always_ff @(posedge ref_clk or negedge rstN)
	begin
		if (!rstN)
		begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end
		else if (clkEn)
		begin
			pready  <= apbAccess;
			// unmapped or misaligned offsets answer with an error and zero data
			prdata  <= (apbAccess && !pwrite && apbHit) ? next_rdata : 32'h0000_0000;
			pslverr <= apbAccess && !apbHit;
		end
	end

	// read mux over the register map
	always_comb
	begin
		next_rdata = 32'h0000_0000;
		case (paddr)
			`SMAD_REG_CTRL:    next_rdata = ctrl;
			`SMAD_REG_SEGATTR: next_rdata = {6'h00, segAttr};
			`SMAD_REG_LOWTOP:  next_rdata = {lowTop, 20'h0_0000};
			`SMAD_REG_PORTMEM: next_rdata = {memLimit, 4'h0, memBase, 4'h0};
			`SMAD_REG_PORTPF:  next_rdata = {pfLimit, 4'h0, pfBase, 4'h0};
			`SMAD_REG_STATUS:  next_rdata = {decodeCnt, 11'h000, iwbSticky, rspInvalid, rspTarget};
			`SMAD_REG_SMMBASE: next_rdata = {smmBase, 20'h0_0000};
			default:
				// window registers share one indexed slot
				if (paddr >= `SMAD_REG_WIN0 && paddr <= `SMAD_REG_WINLAST)
					next_rdata = winReg[3'((paddr - `SMAD_REG_WIN0) >> `SMAD_WIN_SHIFT)];
		endcase
	end

	// ---------------------------------------------------------
	// configuration registers
	// ---------------------------------------------------------
	// top bios segment, like every other, comes up with both directions disabled
	always_ff @(posedge ref_clk or negedge rstN)
	begin
		if (!rstN)
		begin
			ctrl     <= `SMAD_CTRL_RESET;
			segAttr  <= `SMAD_SEG_RESET;                                   // [RQ5]
			lowTop   <= `SMAD_MB_ZERO;
			memBase  <= `SMAD_MB_ZERO;
			memLimit <= `SMAD_MB_ZERO;
			pfBase   <= `SMAD_MB_ZERO;
			pfLimit  <= `SMAD_MB_ZERO;
		end
		else if (clkEn && apbDone && pwrite)
		begin
			case (paddr)
				`SMAD_REG_CTRL:    ctrl <= pwdata & `SMAD_CTRL_MASK;
				`SMAD_REG_SEGATTR: segAttr <= pwdata[`SMAD_SEG_BITS-1:0];      // [RQ6]
				`SMAD_REG_LOWTOP:  lowTop <= pwdata[31:`SMAD_MB_LO];
				`SMAD_REG_PORTMEM:
				begin
					memLimit <= pwdata[31:`SMAD_MB_LO];
					memBase  <= pwdata[`SMAD_LIMIT_LO-1:`SMAD_BASE_LO];
				end
				`SMAD_REG_PORTPF:
				begin
					pfLimit <= pwdata[31:`SMAD_MB_LO];
					pfBase  <= pwdata[`SMAD_LIMIT_LO-1:`SMAD_BASE_LO];
				end
				default: ;
			endcase
		end
	end

	// ---------------------------------------------------------
	// address windows
	// ---------------------------------------------------------
	// windows 0..3 are host-bridge register windows, 4..7 internal graphics
	always_comb
	begin
		winMask[0] = `SMAD_MASK_4K;
		winMask[1] = `SMAD_MASK_16K;
		case (ctrl[`SMAD_CTRL_FLAT_HI:`SMAD_CTRL_FLAT_LO])
			2'h0:    winMask[2] = `SMAD_MASK_64M;
			2'h1:    winMask[2] = `SMAD_MASK_128M;
			default: winMask[2] = `SMAD_MASK_256M;
		endcase
		winMask[3] = `SMAD_MASK_4K;
		winMask[4] = `SMAD_MASK_512K;
		winMask[5] = `SMAD_MASK_512K;
		case (ctrl[`SMAD_CTRL_APER_HI:`SMAD_CTRL_APER_LO])
			2'h0:    winMask[6] = `SMAD_MASK_128M;
			2'h1:    winMask[6] = `SMAD_MASK_256M;
			default: winMask[6] = `SMAD_MASK_512M;
		endcase
		winMask[7] = `SMAD_MASK_1M;
	end

	// overlapping windows are not interlocked; software keeps them apart
	for (genvar w = 0; w < `SMAD_WIN_COUNT; w++)
	begin : gWin
		always_ff @(posedge ref_clk or negedge rstN)
		begin
			if (!rstN)
				winReg[w] <= 32'h0000_0000;
			else if (clkEn && apbDone && pwrite && paddr == `SMAD_REG_WIN0 + 8'(w << `SMAD_WIN_SHIFT))
				winReg[w] <= pwdata;
		end
		assign winHit[w] = winReg[w][`SMAD_WIN_EN]
			&& ((reqAddr & winMask[w]) == (winReg[w] & winMask[w]));      // [RQ20] [RQ22] [RQ23]
	end

	// ---------------------------------------------------------
	// legacy segment lookup
	// ---------------------------------------------------------
	smad_seg_if segBus ();
	assign segBus.addr  = reqAddr;
	assign segBus.write = reqWrite;
	assign segBus.attr  = segAttr;

	smad_legacy_seg uSeg
	(
		.seg (segBus.lookup)
	);

	// ---------------------------------------------------------
	// low memory regions
	// ---------------------------------------------------------
	// stolen graphics sits at the top of low dram, the smm segment just under it
	always_comb
	begin
		case (ctrl[`SMAD_CTRL_SMM_TOP_SEGMENT_HI:`SMAD_CTRL_SMM_TOP_SEGMENT_LO])
			2'h1:    tsegMb = `SMAD_MB_2;                                  // [RQ12]
			2'h2:    tsegMb = `SMAD_MB_8;
			default: tsegMb = `SMAD_MB_1;
		endcase
		if (!ctrl[`SMAD_CTRL_IGD])
		begin
			gmsMb = `SMAD_MB_ZERO;
			gttMb = `SMAD_MB_ZERO;
		end
		else
		begin
			// codes 1..7 give 4..256 mb, code 0 gives 1 mb
			gmsMb = (ctrl[`SMAD_CTRL_GMS_HI:`SMAD_CTRL_GMS_LO] == 3'h0) ? `SMAD_MB_1
				: `SMAD_GMS_STEP << ctrl[`SMAD_CTRL_GMS_HI:`SMAD_CTRL_GMS_LO]; // [RQ17]
			gttMb = ctrl[`SMAD_CTRL_GTT] ? `SMAD_MB_2 : `SMAD_MB_1;        // [RQ18]
		end
		stolenBase = lowTop - gttMb - gmsMb;
		smmBase    = stolenBase - tsegMb;                                  // [RQ12]
	end

	assign addrMb   = reqAddr[31:`SMAD_MB_LO];
	assign inLegacy = segBus.hit;
	assign inLow    = addrMb < lowTop;
	assign inHole   = ctrl[`SMAD_CTRL_HOLE] && addrMb == `SMAD_HOLE_MB;
	assign inSmm    = ctrl[`SMAD_CTRL_SMM] && addrMb >= smmBase && addrMb < stolenBase;
	assign inStolen = addrMb >= stolenBase && inLow;
	assign nsLegacy = inLegacy && !reqSnoop
		&& (reqSrc == SMAD_SRC_PORT || reqSrc == SMAD_SRC_DOWNLINK);

	// ---------------------------------------------------------
	// routing decision
	// ---------------------------------------------------------
	// a disabled segment or hole never relocates the dram under it: the
	// address passes through unchanged, only the target differs
	always_comb
	begin
		next_tgt  = SMAD_TGT_DOWNLINK;
		next_addr = reqAddr;                                               // [RQ2] [RQ13]
		next_be   = reqBe;
		next_inv  = 1'b0;
		if (inLegacy)
		begin
			if (nsLegacy)
				next_tgt = SMAD_TGT_DRAM;                                  // [RQ3]
			else if (segBus.allow)
				next_tgt = SMAD_TGT_DRAM;                                  // [RQ24] [RQ6]
			else
				next_tgt = SMAD_TGT_DOWNLINK;                              // [RQ8]
		end
		else if (addrMb == `SMAD_LEGACY_MB)
			next_tgt = SMAD_TGT_DRAM;
		else if (inLow)
		begin
			if (inHole)
				next_tgt = SMAD_TGT_DOWNLINK;                              // [RQ11]
			else if (inSmm)
			begin
				next_tgt = SMAD_TGT_DRAM;
				// processor writebacks complete normally; other strays are neutralised
				if (reqSrc != SMAD_SRC_CPU
					|| (ctrl[`SMAD_CTRL_ESMRAM] && !reqIwb && (!reqSmm || !reqWb))) // [RQ14] [RQ15] [RQ16]
				begin
					next_inv  = 1'b1;
					next_addr = `SMAD_ADDR_ZERO;
					next_be   = `SMAD_BE_NONE;
				end
			end
			else if (inStolen)
				next_tgt = (reqSrc == SMAD_SRC_IGFX) ? SMAD_TGT_DRAM : SMAD_TGT_DOWNLINK;
			else
				next_tgt = SMAD_TGT_DRAM;                                  // [RQ10]
		end
		else if (|winHit[3:0])
			next_tgt = SMAD_TGT_INTERNAL;                                  // [RQ20]
		else if ((addrMb >= memBase && addrMb <= memLimit) || (addrMb >= pfBase && addrMb <= pfLimit))
			next_tgt = SMAD_TGT_PORT;                                      // [RQ21]
		else if (ctrl[`SMAD_CTRL_IGD] && |winHit[7:4])
			next_tgt = SMAD_TGT_IGFX;                                      // [RQ22]
		else
			next_tgt = SMAD_TGT_DOWNLINK;                                  // [RQ19]
	end

	// writebacks cannot be serviced on the downlink; only recorded for software
	assign next_iwb = reqValid && reqIwb && next_tgt == SMAD_TGT_DOWNLINK; // [RQ9]

	// ---------------------------------------------------------
	// result and status registers
	// ---------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rstN)
	begin
		if (!rstN)
		begin
			rspValid   <= 1'b0;
			rspTarget  <= SMAD_TGT_DRAM;
			rspAddr    <= `SMAD_ADDR_ZERO;
			rspBe      <= `SMAD_BE_NONE;
			rspInvalid <= 1'b0;
			decodeCnt  <= 16'h0000;
		end
		else if (clkEn)
		begin
			rspValid <= reqValid;
			if (reqValid)
			begin
				rspTarget  <= next_tgt;
				rspAddr    <= next_addr;
				rspBe      <= next_be;
				rspInvalid <= next_inv;
				decodeCnt  <= decodeCnt + 16'h0001;
			end
		end
	end

	// sticky flag, write one to clear; a new event in the clearing cycle wins
	always_ff @(posedge ref_clk or negedge rstN)
	begin
		if (!rstN)
			iwbSticky <= 1'b0;
		else if (clkEn)
		begin
			if (next_iwb)
				iwbSticky <= 1'b1;                                         // [RQ9]
			else if (apbDone && pwrite && paddr == `SMAD_REG_STATUS && pwdata[`SMAD_STAT_IWB])
				iwbSticky <= 1'b0;
		end
	end

	// ---------------------------------------------------------
	// checks
	// ---------------------------------------------------------
	a_invalid_addr_zero: assert property (@(posedge ref_clk) disable iff (!rstN) // [RQ14]
		rspValid && rspInvalid |-> rspAddr == `SMAD_ADDR_ZERO && rspBe == `SMAD_BE_NONE)
		else $error("invalid cycle not redirected to zero");
	a_nonsnoop_legacy_dram: assert property (@(posedge ref_clk) disable iff (!rstN) // [RQ3]
		clkEn && reqValid && nsLegacy |=> rspTarget == SMAD_TGT_DRAM)
		else $error("non-snooped legacy access not sent to dram");
	a_segment_direction: assert property (@(posedge ref_clk) disable iff (!rstN) // [RQ24]
		clkEn && reqValid && inLegacy && !nsLegacy |=> rspTarget == ($past(segBus.allow)
			? SMAD_TGT_DRAM : SMAD_TGT_DOWNLINK))
		else $error("legacy segment routed against its attribute");
	a_hole_downlink: assert property (@(posedge ref_clk) disable iff (!rstN) // [RQ11]
		clkEn && reqValid && inHole && inLow |=> rspTarget == SMAD_TGT_DOWNLINK && !rspInvalid)
		else $error("fixed hole access not sent to downlink");
	a_smm_same_addr: assert property (@(posedge ref_clk) disable iff (!rstN) // [RQ13]
		clkEn && reqValid && inSmm && inLow && !inHole && reqSrc == SMAD_SRC_CPU && reqSmm && reqWb
		|=> rspTarget == SMAD_TGT_DRAM && rspAddr == $past(reqAddr) && !rspInvalid)
		else $error("smm processor access translated");
	a_smm_foreign_inv: assert property (@(posedge ref_clk) disable iff (!rstN) // [RQ14]
		clkEn && reqValid && inSmm && inLow && !inHole && reqSrc != SMAD_SRC_CPU |=> rspInvalid)
		else $error("foreign access to smm segment not invalidated");
	a_smm_writeback_ok: assert property (@(posedge ref_clk) disable iff (!rstN) // [RQ16]
		clkEn && reqValid && inSmm && inLow && !inHole && reqSrc == SMAD_SRC_CPU && reqIwb |=> !rspInvalid)
		else $error("smm writeback not completed to dram");
	a_window_internal: assert property (@(posedge ref_clk) disable iff (!rstN) // [RQ20]
		clkEn && reqValid && !inLow && !inLegacy && addrMb != `SMAD_LEGACY_MB && |winHit[3:0]
		|=> rspTarget == SMAD_TGT_INTERNAL)
		else $error("host-bridge window not claimed");
	a_pci_default: assert property (@(posedge ref_clk) disable iff (!rstN) // [RQ19]
		clkEn && reqValid && !inLow && addrMb != `SMAD_LEGACY_MB && winHit == '0
		&& !(addrMb >= memBase && addrMb <= memLimit) && !(addrMb >= pfBase && addrMb <= pfLimit)
		|=> rspTarget == SMAD_TGT_DOWNLINK)
		else $error("unclaimed high address not sent to downlink");
	a_iwb_sticky: assert property (@(posedge ref_clk) disable iff (!rstN) // [RQ9]
		clkEn && next_iwb |=> iwbSticky [*2] or (iwbSticky ##1 (!iwbSticky && $past(apbDone && pwrite))))
		else $error("writeback flag lost");
	a_apb_one_wait: assert property (@(posedge ref_clk) disable iff (!rstN)
		clkEn && apbAccess ##1 clkEn |-> pready ##1 !pready)
		else $error("apb answer not after one wait state");

endmodule

// ==== smad_initiator.sv ====
/* initiator model: issues one memory access at a time to the decoder.
   assumes the decoder answers one edge after the request edge. */
`timescale 1ns/1ps
module smad_initiator
	import smad_pkg::*;
(
	// clock and answer
	input  wire logic   clk,
	input  wire logic   rspValid,
	// request fields
	output logic        reqValid,
	output logic [31:0] reqAddr,
	output smad_src_t   reqSrc,
	output logic        reqWrite,
	output logic        reqSnoop,
	output logic        reqSmm,
	output logic        reqWb,
	output logic        reqIwb,
	output logic [7:0]  reqBe
);
	// idle at time zero; write-back type, full byte enables
	initial
	begin
		{reqValid, reqAddr, reqWrite, reqSnoop, reqSmm, reqIwb} = '0;
		reqSrc = SMAD_SRC_CPU;
		reqWb = 1'b1;
		reqBe = 8'hFF;
	end
	// one-edge request; the address turns over after it so no stale value lingers
	task automatic issue(input logic [31:0] a, input smad_src_t s, input logic w, sn, sm, implicit_writeback_cycle, output logic ok);
		ok = 1'b0;
		@(posedge clk);
		{reqValid, reqAddr, reqWrite, reqSnoop, reqSmm, reqIwb} <= {1'b1, a, w, sn, sm, implicit_writeback_cycle};
		reqSrc <= s;
		@(posedge clk);
		reqValid <= 1'b0;
		reqAddr <= ~a;
		repeat (3) @(negedge clk) ok = ok | (rspValid === 1'b1);
	endtask
endmodule

// ==== smad_bench.sv ====
/* self-checking bench: apb set-up of the decoder, then routed accesses.
   assumes the initiator model shares the one clock. */
`timescale 1ns/1ps
`include "smad_defs.svh"
module smad_bench
	import smad_pkg::*;
;
	logic        refClk = 1'b0, rstN = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00, reqBe, rspBe;
	logic [31:0] pwdata = 32'h0, prdata, reqAddr, rspAddr, q;
	logic        pready, pslverr, reqValid, reqWrite, reqSnoop, reqSmm, reqWb, reqIwb, rspValid, rspInvalid, e;
	logic        held, clkEn = 1'b1;
	smad_src_t   reqSrc;
	smad_tgt_t   rspTarget;
	int          failCount = 0, checkCount = 0;
	smad_top dut (.ref_clk(refClk), .rst_n(rstN), .clkEn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
		.prdata, .pslverr, .reqValid, .reqAddr, .reqSrc, .reqWrite, .reqSnoop, .reqSmm, .reqWb, .reqIwb, .reqBe,
		.rspValid, .rspTarget, .rspAddr, .rspBe, .rspInvalid);
	smad_initiator ini (.clk(refClk), .rspValid, .reqValid, .reqAddr, .reqSrc, .reqWrite, .reqSnoop, .reqSmm,
		.reqWb, .reqIwb, .reqBe);
	initial
	begin
		forever #50 refClk = ~refClk;
	end
	task automatic check(input string what, input logic [31:0] seen, exp);
		checkCount++;
		if (seen !== exp)
		begin
			failCount++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic completeRun;
		$display("checks %0d mismatches %0d", checkCount, failCount);
		if (failCount == 0 && checkCount > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// one apb transfer; request held until pready is sampled high at a rising edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge refClk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge refClk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge refClk);
			n++;
		end
		while (pready !== 1'b1 && n < 8);
		{q, e} = {prdata, pslverr};
		{psel, penable} <= 2'b00;
		if (pready !== 1'b1)
		begin
			check("apb timeout", 32'h1, 32'h0);
			completeRun();
		end
	endtask
	// one access; invalid cycles carry address 0 and no byte enables
	task automatic req(input logic [31:0] a, input smad_src_t s, input logic w, sn, sm, input smad_tgt_t t, logic v,
		logic implicit_writeback_cycle = 1'b0);
		logic ok;
		ini.issue(a, s, w, sn, sm, implicit_writeback_cycle, ok);
		check("answer", {31'h0, ok}, 32'h1);
		check("target", {29'h0, rspTarget}, {29'h0, t});
		check("address", rspAddr, v ? 32'h0 : a);
		check("bytes", {24'h0, rspBe}, v ? 32'h0 : 32'hFF);
		check("invalid", {31'h0, rspInvalid}, {31'h0, v});
	endtask
	initial
	begin
		repeat (2) @(posedge refClk);
		rstN <= 1'b1;
		repeat (3) @(posedge refClk);
		apb(0, `SMAD_REG_SEGATTR, 0);
		check("segattr", q, 32'h0);
		req(32'hF0000, SMAD_SRC_CPU, 0, 1, 0, SMAD_TGT_DOWNLINK, 0);
		@(posedge refClk) clkEn <= 1'b0;
		ini.issue(32'hC4000, SMAD_SRC_CPU, 0, 1, 0, 0, held);
		@(posedge refClk) clkEn <= 1'b1;
		check("frozen", {31'h0, held}, 32'h0);
		apb(1, `SMAD_REG_SEGATTR, 32'h0120_0008);
		req(32'hF0000, SMAD_SRC_CPU, 0, 1, 0, SMAD_TGT_DRAM, 0);
		req(32'hF0000, SMAD_SRC_CPU, 1, 1, 0, SMAD_TGT_DOWNLINK, 0);
		req(32'hC4000, SMAD_SRC_CPU, 1, 1, 0, SMAD_TGT_DRAM, 0);
		req(32'hC4000, SMAD_SRC_CPU, 0, 1, 0, SMAD_TGT_DOWNLINK, 0);
		req(32'hE8000, SMAD_SRC_CPU, 0, 1, 0, SMAD_TGT_DOWNLINK, 0);
		req(32'hE8000, SMAD_SRC_CPU, 1, 1, 0, SMAD_TGT_DRAM, 0);
		req(32'hC0000, SMAD_SRC_PORT, 0, 0, 0, SMAD_TGT_DRAM, 0);
		req(32'hC0000, SMAD_SRC_DOWNLINK, 0, 1, 0, SMAD_TGT_DOWNLINK, 0);
		req(32'hC0000, SMAD_SRC_CPU, 0, 1, 0, SMAD_TGT_DOWNLINK, 0, 1);
		apb(0, `SMAD_REG_STATUS, 0);
		check("status", q & 32'h1F, 32'h11);
		apb(1, `SMAD_REG_STATUS, 32'h10);
		apb(0, `SMAD_REG_STATUS, 0);
		check("status clear", q & 32'h1F, 32'h01);
		apb(1, `SMAD_REG_LOWTOP, 32'h0400_0000);
		apb(1, `SMAD_REG_CTRL, 32'h0000_0003);
		req(32'hF8_0000, SMAD_SRC_CPU, 0, 1, 0, SMAD_TGT_DOWNLINK, 0);
		req(32'h200_0000, SMAD_SRC_CPU, 1, 1, 0, SMAD_TGT_DRAM, 0);
		apb(0, `SMAD_REG_SMMBASE, 0);
		check("smm base", q, 32'h03F0_0000);
		req(32'h3F0_0100, SMAD_SRC_CPU, 0, 1, 1, SMAD_TGT_DRAM, 0);
		req(32'h3F0_0100, SMAD_SRC_PORT, 1, 1, 0, SMAD_TGT_DRAM, 1);
		apb(1, `SMAD_REG_CTRL, 32'h0000_0007);
		req(32'h3F0_0100, SMAD_SRC_CPU, 0, 1, 0, SMAD_TGT_DRAM, 1);
		req(32'h3F0_0100, SMAD_SRC_CPU, 1, 1, 0, SMAD_TGT_DRAM, 0, 1);
		req(32'h8000_0000, SMAD_SRC_CPU, 0, 1, 0, SMAD_TGT_DOWNLINK, 0);
		apb(1, `SMAD_REG_PORTMEM, 32'h8000_8000);
		req(32'h8000_0000, SMAD_SRC_CPU, 0, 1, 0, SMAD_TGT_PORT, 0);
		apb(1, `SMAD_REG_WIN0, 32'h9000_0001);
		req(32'h9000_0010, SMAD_SRC_CPU, 0, 1, 0, SMAD_TGT_INTERNAL, 0);
		apb(1, `SMAD_REG_CTRL, 32'h0000_110B);
		apb(0, `SMAD_REG_SMMBASE, 0);
		check("smm base igd", q, 32'h0390_0000);
		apb(1, `SMAD_REG_WINLAST, 32'hA000_0001);
		req(32'hA000_0000, SMAD_SRC_CPU, 0, 1, 0, SMAD_TGT_IGFX, 0);
		req(32'h3A0_0000, SMAD_SRC_IGFX, 0, 1, 0, SMAD_TGT_DRAM, 0);
		req(32'h3A0_0000, SMAD_SRC_CPU, 0, 1, 0, SMAD_TGT_DOWNLINK, 0);
		apb(0, 8'h3C, 0);
		check("unmapped error", {31'h0, e}, 32'h1);
		completeRun();
	end
endmodule
